// ==== verilog/ocs_consts.vh ====
// constants of the operation-complete synchronisation block
`ifndef OCS_CONSTS_VH
`define OCS_CONSTS_VH
`define OCS_CLK_HZ 100000000
`define OCS_SETTLE_MS 1000
`define OCS_SETTLE_CYC ((`OCS_CLK_HZ / 1000) * `OCS_SETTLE_MS)
`define OCS_MEAS_N 8
`define OCS_ASCII_ONE 8'h31
`define OCS_ESR_OPC 0
`define OCS_STB_MAV 4
`define OCS_STB_ESB 5
`define OCS_STB_RQS 6
`define OCS_ADDR_W 4
`define OCS_A_ESR 4'h0
`define OCS_A_ESE 4'h1
`define OCS_A_STB 4'h2
`define OCS_A_SRE 4'h3
`define OCS_A_OQ 4'h4
`define OCS_A_IRQ_ST 4'h5
`define OCS_A_IRQ_CLR 4'h6
`define OCS_A_IRQ_EN 4'h7
`define OCS_A_CTRL 4'h8
`define OCS_A_STAT 4'h9
`define OCS_IRQ_W 3
`define OCS_IRQ_OPC 0
`define OCS_IRQ_MAV 1
`define OCS_IRQ_SRQ 2
`define OCS_CTRL_PCS 0
`define OCS_CMD_NONE 2'h0
`define OCS_CMD_OPC 2'h1
`define OCS_CMD_OPCQ 2'h2
`define OCS_CMD_WAI 2'h3
`endif

// ==== verilog/ocs_settle_timer.v ====
// one-second settling timer, restarted by each start pulse
`include "ocs_consts.vh"
module ocs_settle_timer #(
  parameter CYCLES = `OCS_SETTLE_CYC
) (
  input wire mclk,
  input wire rst_n,
  input wire start,
  input wire abort,
  output reg running,
  output reg expired
);
  reg [31:0] count;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 32'h0;
      running <= 1'b0;
      expired <= 1'b0;
    end else if (abort) begin
      count <= 32'h0;
      running <= 1'b0;
      expired <= 1'b0;
    end else if (start) begin
      count <= CYCLES - 1;
      running <= 1'b1;
      expired <= 1'b0;
    end else if (running) begin
      if (count == 32'h0) begin
        running <= 1'b0;
        expired <= 1'b1;
      end else begin
        count <= count - 32'h1;
      end
    end
  end
endmodule // ocs_settle_timer

// ==== verilog/ocs_sync.v ====
// operation-complete synchronisation: settling timer, measurement polling, status
`include "ocs_consts.vh"
// How it works
// - opc command sets event bit 0 when done
// - opc, opc query, wait start settle timer
// - ask all active measurements to report done
// - complete needs timer expired and all done
// - with option, invalid result blocks completion
// - without option, invalid result still completes
// - opc query enqueues ascii one when done
// - enqueued response sets message-available bit
// - event bit0, event enable bit0 and enable bit5 raise request
// - enable bit4 plus message-available raises request
// - query response waits for preceding commands
// - bus held off while response awaited
// - call-state command never finishes, blocks response
// - reset command drops pending opc and query
// - wait suspends later commands until complete
module ocs_sync #(
  parameter MEAS_N = `OCS_MEAS_N,
  parameter SETTLE_CYC = `OCS_SETTLE_CYC
) (
  input wire mclk,
  input wire rst_n,
  input wire [1:0] cmd_code,
  input wire cmd_valid,
  input wire cmd_call_state,
  input wire rst_cmd,
  input wire [MEAS_N-1:0] meas_active,
  input wire [MEAS_N-1:0] meas_done,
  input wire [MEAS_N-1:0] meas_valid,
  input wire oq_ready,
  input wire [`OCS_ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  output reg [MEAS_N-1:0] meas_report_req,
  output wire cmd_hold,
  output wire oq_holdoff,
  output reg oq_valid,
  output reg [7:0] oq_data,
  output wire srq,
  output wire irq
);
  // stuck: a call-state command ahead of the request never completes
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_STUCK = 2'h2;

  reg [1:0] state;
  reg [1:0] pend_kind;
  reg [MEAS_N-1:0] snap_active;
  wire [MEAS_N-1:0] got_done;
  reg esr_opc;
  reg [7:0] ese;
  reg [7:0] sre;
  reg pcs_option;
  reg mav;
  reg [`OCS_IRQ_W-1:0] irq_st;
  reg [`OCS_IRQ_W-1:0] irq_en;
  reg srq_d;
  reg [1:0] next_state;
  reg [7:0] next_rdata;

  wire tmr_running;
  wire tmr_expired;
  wire start_req;
  wire all_done;
  wire invalid_block;
  wire satisfied;
  wire ess;
  wire [7:0] stb;
  wire opc_event;
  wire mav_event;
  wire srq_event;
  wire oq_read;
  wire irq_clr_wr;

  wire esr_rd;
  wire ese_wr;
  wire sre_wr;
  wire ctrl_wr;
  wire irq_en_wr;
  wire load_req;
  wire drop_req;
  genvar gi;

  function sel;
    input [`OCS_ADDR_W-1:0] a;
    input [`OCS_ADDR_W-1:0] b;
    begin
      sel = (a == b);
    end
  endfunction

  assign start_req = cmd_valid && (cmd_code != `OCS_CMD_NONE) && !rst_cmd;
  assign oq_read = reg_rd && sel(reg_addr, `OCS_A_OQ);
  assign irq_clr_wr = reg_wr && sel(reg_addr, `OCS_A_IRQ_CLR);
  // register strobes decoded once, shared by the blocks below
  assign esr_rd = reg_rd && sel(reg_addr, `OCS_A_ESR);
  assign ese_wr = reg_wr && sel(reg_addr, `OCS_A_ESE);
  assign sre_wr = reg_wr && sel(reg_addr, `OCS_A_SRE);
  assign ctrl_wr = reg_wr && sel(reg_addr, `OCS_A_CTRL);
  assign irq_en_wr = reg_wr && sel(reg_addr, `OCS_A_IRQ_EN);

  // restarted by every accepted request, so the wait always runs full length

  ocs_settle_timer #(
    .CYCLES(SETTLE_CYC)
  ) u_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .start(start_req),
    .abort(rst_cmd),
    .running(tmr_running),
    .expired(tmr_expired)
  );

  // a measurement counts done once it reported while being asked
  assign all_done = ((got_done | meas_done) & snap_active) == snap_active;
  assign invalid_block = pcs_option && |(snap_active & ~meas_valid);
  assign satisfied = (state == ST_WAIT) && tmr_expired && all_done && !invalid_block;
  assign load_req = start_req && (state != ST_STUCK);
  assign drop_req = rst_cmd || satisfied;

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_req) begin
          next_state = cmd_call_state ? ST_STUCK : ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (rst_cmd) begin
          next_state = ST_IDLE;
        end else if (start_req) begin
          next_state = cmd_call_state ? ST_STUCK : ST_WAIT;
        end else if (satisfied) begin
          next_state = ST_IDLE;
        end
      end
      ST_STUCK: begin
        if (rst_cmd) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pend_kind <= `OCS_CMD_NONE;
    end else if (load_req) begin
      pend_kind <= cmd_code;
    end else if (drop_req) begin
      pend_kind <= `OCS_CMD_NONE;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      snap_active <= {MEAS_N{1'b0}};
    end else if (load_req) begin
      snap_active <= meas_active;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meas_report_req <= {MEAS_N{1'b0}};
    end else if (load_req) begin
      meas_report_req <= meas_active;
    end else if (drop_req) begin
      meas_report_req <= {MEAS_N{1'b0}};
    end
  end

  // one done catcher per measurement; a report counts only while it is asked for
  generate
    for (gi = 0; gi < MEAS_N; gi = gi + 1) begin : g_meas
      reg seen;
      always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          seen <= 1'b0;
        end else if (load_req || drop_req) begin
          seen <= 1'b0;
        end else if (meas_done[gi] && meas_report_req[gi]) begin
          seen <= 1'b1;
        end
      end
      assign got_done[gi] = seen;
    end
  endgenerate

  // later commands stall while any completion request is outstanding
  assign cmd_hold = (state != ST_IDLE);
  assign oq_holdoff = (state != ST_IDLE) && (pend_kind == `OCS_CMD_OPCQ);

  assign opc_event = satisfied && (pend_kind == `OCS_CMD_OPC);
  assign mav_event = satisfied && (pend_kind == `OCS_CMD_OPCQ);

  // event set wins over a read-clear in the same cycle
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      esr_opc <= 1'b0;
    end else if (opc_event) begin
      esr_opc <= 1'b1;
    end else if (esr_rd) begin
      esr_opc <= 1'b0;
    end
  end

  // a new response wins over a pop in the same cycle
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      oq_valid <= 1'b0;
      mav <= 1'b0;
    end else if (mav_event) begin
      oq_valid <= 1'b1;
      mav <= 1'b1;
    end else if (oq_read || (oq_valid && oq_ready)) begin
      oq_valid <= 1'b0;
      mav <= 1'b0;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      oq_data <= 8'h00;
    end else if (mav_event) begin
      oq_data <= `OCS_ASCII_ONE;
    end
  end

  // status byte: summary bits of the message and event paths
  assign ess = |({7'h00, esr_opc} & ese);
  assign stb[3:0] = 4'h0;
  assign stb[`OCS_STB_MAV] = mav;
  assign stb[`OCS_STB_ESB] = ess;
  assign stb[`OCS_STB_RQS] = srq;
  assign stb[7] = 1'b0;
  assign srq = (ess && sre[`OCS_STB_ESB]) || (mav && sre[`OCS_STB_MAV]);

  assign srq_event = srq && !srq_d;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      srq_d <= 1'b0;
    end else begin
      srq_d <= srq;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ese <= 8'h00;
    end else if (ese_wr) begin
      ese <= reg_wdata;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sre <= 8'h00;
    end else if (sre_wr) begin
      sre <= reg_wdata;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pcs_option <= 1'b0;
    end else if (ctrl_wr) begin
      pcs_option <= reg_wdata[`OCS_CTRL_PCS];
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_en <= {`OCS_IRQ_W{1'b0}};
    end else if (irq_en_wr) begin
      irq_en <= reg_wdata[`OCS_IRQ_W-1:0];
    end
  end

  // a clear and a new event in one cycle leave the bit set
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_st <= {`OCS_IRQ_W{1'b0}};
    end else begin
      irq_st <= (irq_st & ~(irq_clr_wr ? reg_wdata[`OCS_IRQ_W-1:0] : {`OCS_IRQ_W{1'b0}}))
        | {srq_event, mav_event, opc_event};
    end
  end

  // level interrupt while any enabled sticky bit is set
  assign irq = |(irq_st & irq_en);

  // read mux; the flop below shows the word in the cycle after the strobe
  always @* begin
    next_rdata = 8'h00;
    case (reg_addr)
      `OCS_A_ESR: next_rdata = {7'h00, esr_opc};
      `OCS_A_ESE: next_rdata = ese;
      `OCS_A_STB: next_rdata = stb;
      `OCS_A_SRE: next_rdata = sre;
      `OCS_A_OQ: next_rdata = oq_valid ? oq_data : 8'h00;
      `OCS_A_IRQ_ST: next_rdata = {5'h00, irq_st};
      `OCS_A_IRQ_EN: next_rdata = {5'h00, irq_en};
      `OCS_A_CTRL: next_rdata = {7'h00, pcs_option};
      `OCS_A_STAT: next_rdata = {3'h0, tmr_expired, tmr_running, pend_kind, state == ST_STUCK};
      default: next_rdata = 8'h00;
    endcase
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end
endmodule // ocs_sync

// ==== verification/ocs_sync_chk.sv ====
// assertion checker for the completion sync block
module ocs_sync_chk #(
  parameter MEAS_N = 8
) (
  input logic mclk,
  input logic rst_n,
  input logic [1:0] cmd_code,
  input logic cmd_valid,
  input logic cmd_call_state,
  input logic rst_cmd,
  input logic [MEAS_N-1:0] meas_active,
  input logic [MEAS_N-1:0] meas_done,
  input logic [3:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic reg_wr,
  input logic [MEAS_N-1:0] meas_report_req,
  input logic cmd_hold,
  input logic oq_holdoff,
  input logic oq_valid,
  input logic [7:0] oq_data,
  input logic srq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic [7:0] sre;
  wire acc = cmd_valid && !cmd_hold && !rst_cmd && cmd_code != 2'h0;
  // mirror of the service request enable
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) sre <= 8'h00;
    else if (reg_wr && reg_addr == 4'h3) sre <= reg_wdata;
  end
  chk_hold_set: assert property (acc |=> cmd_hold)
    else $error("request not held");
  chk_req_snap: assert property (acc |=> meas_report_req == $past(meas_active))
    else $error("report request mismatch");
  chk_no_early: assert property (acc |=> (!$rose(oq_valid)) [*8])
    else $error("early completion");
  chk_rst_drop: assert property (rst_cmd |=> !cmd_hold && !oq_holdoff)
    else $error("reset left request");
  chk_stuck_hold: assert property (acc && cmd_call_state |=> cmd_hold [*8])
    else $error("call state completed");
  chk_ascii_one: assert property (oq_valid |-> oq_data == 8'h31)
    else $error("bad response byte");
  chk_done_gate: assert property ($rose(oq_valid) |-> $past(&(meas_done | ~meas_report_req)))
    else $error("response before done");
  chk_mav_srq: assert property ($rose(oq_valid) && sre[4] |-> srq)
    else $error("no service request");
  chk_held_off: assert property ($rose(oq_valid) |-> $past(oq_holdoff))
    else $error("no holdoff");
endmodule // ocs_sync_chk

// ==== verification/ocs_meas_model.sv ====
// measurement array model answering report requests
module ocs_meas_model (
  input logic mclk,
  input logic rst_n,
  input logic meas_slow,
  input logic [7:0] meas_report_req,
  output logic [7:0] meas_done
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      meas_done <= 8'h00;
    end else if (meas_report_req == 8'h00) begin
      cnt <= 0;
      meas_done <= 8'h00;
    end else if (cnt == (meas_slow ? 40 : 2)) meas_done <= meas_report_req;
    else cnt <= cnt + 1;
  end
endmodule // ocs_meas_model

// ==== verification/ocs_sync_tb.sv ====
// testbench for the completion sync block
module ocs_sync_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] cmd_code = 2'h0;
  logic cmd_valid = 1'b0;
  logic cmd_call_state = 1'b0;
  logic rst_cmd = 1'b0;
  logic [7:0] meas_active = 8'h0f;
  logic [7:0] meas_valid = 8'hff;
  logic oq_ready = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic meas_slow = 1'b0;
  wire [7:0] meas_done, reg_rdata, meas_report_req, oq_data;
  wire cmd_hold, oq_holdoff, oq_valid, srq, irq;
  int n_fail = 0;
  int n_tests = 0;
  int c;
  ocs_sync #(.SETTLE_CYC(20)) DUT (.*);
  ocs_meas_model u_meas (.*);
  initial forever #5 mclk = ~mclk;
  task results;
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
  endtask
  task cmd(input logic [1:0] k, input logic s);
    @(posedge mclk);
    cmd_code <= k;
    cmd_call_state <= s;
    cmd_valid <= 1'b1;
    @(posedge mclk);
    cmd_valid <= 1'b0;
  endtask
  task wt;
    c = 0;
    do begin
      @(posedge mclk);
      #1;
      c++;
    end while (cmd_hold !== 1'b0 && c < 100);
    if (c >= 100) begin
      n_fail++;
      results();
    end
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task rcmd;
    @(posedge mclk);
    rst_cmd <= 1'b1;
    @(posedge mclk);
    rst_cmd <= 1'b0;
    @(posedge mclk);
    #1;
    chk({7'h0, cmd_hold}, 8'h00);
  endtask
  task t_query;
    wr(4'h3, 8'h10);
    wr(4'h7, 8'h07);
    cmd(2'h2, 1'b0);
    wt();
    chk(8'(c >= 20), 8'h01);
    chk({oq_data}, 8'h31);
    chk({6'h0, irq, srq}, 8'h03);
    rd(4'h2);
    chk(reg_rdata & 8'h10, 8'h10);
    rd(4'h4);
    chk(reg_rdata, 8'h31);
    chk({oq_valid, srq, 6'h0}, 8'h00);
    wr(4'h6, 8'h07);
    @(posedge mclk);
    #1;
    chk({7'h0, irq}, 8'h00);
  endtask
  task t_opc;
    wr(4'h7, 8'h00);
    wr(4'h3, 8'h20);
    wr(4'h1, 8'h01);
    wr(4'hf, 8'hff);
    meas_slow <= 1'b1;
    cmd(2'h1, 1'b0);
    wt();
    chk(8'(c > 40), 8'h01);
    chk({6'h0, irq, srq}, 8'h01);
    rd(4'h0);
    chk(reg_rdata & 8'h01, 8'h01);
    chk({7'h0, srq}, 8'h00);
    rd(4'h1);
    chk(reg_rdata, 8'h01);
    @(posedge mclk);
    meas_slow <= 1'b0;
  endtask
  task t_pcs;
    wr(4'h8, 8'h01);
    meas_valid <= 8'hfe;
    cmd(2'h3, 1'b0);
    repeat (60) @(posedge mclk);
    #1;
    chk({7'h0, cmd_hold}, 8'h01);
    rcmd();
    wr(4'h8, 8'h00);
    cmd(2'h3, 1'b0);
    wt();
    chk({7'h0, oq_valid}, 8'h00);
  endtask
  task t_stuck;
    cmd(2'h2, 1'b1);
    meas_valid <= 8'hff;
    repeat (60) @(posedge mclk);
    #1;
    chk({cmd_hold, oq_valid, 6'h0}, 8'h80);
    rcmd();
    cmd(2'h2, 1'b0);
    wt();
    chk({7'h0, oq_valid}, 8'h01);
    @(posedge mclk);
    oq_ready <= 1'b1;
    @(posedge mclk);
    oq_ready <= 1'b0;
    #1;
    chk({7'h0, oq_valid}, 8'h00);
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    t_query();
    t_opc();
    t_pcs();
    t_stuck();
    results();
  end
endmodule // ocs_sync_tb
bind ocs_sync ocs_sync_chk #(.MEAS_N(MEAS_N)) u_chk (.*);
